// ---- ccs_regs.vh ----
// register map, field positions, reset values and timing constants of the charge supervisor
//
// Contract
// - terminate when above recharge level and current below termination; battery switch off
// - on termination phase code becomes 11 and one alert pulse issues
// - no termination during input current, input voltage or thermal regulation
// - terminate-allow bit at 0 blocks termination; host clears it beforehand
// - top-off timer follows safety timer pause and half-rate counting
// - readable bit shows top-off timer running
// - top-off reset on enable rise, termination rise or register reset
// - top-off length captured at termination; later writes wait for recharge
// - alert pulse at top-off start and at top-off expiry
// - charge only inside outer thermistor range; suspend outside, resume inside
// - warm band regulates to target or 4.1V per warm voltage select
// - cool band reduces current per cool current select, lowest 20 percent
// - boost thermistor out of range: suspend boost, source code 000, fault
// - boost hot limit 11 reports fault but keeps boost running
// - safety limit 2 hours below low-voltage level, programmed limit otherwise
// - safety expiry sets fault code 11 and issues alert pulse
// - safety-timer-allow cleared disables safety timer entirely
// - half-rate safety count during regulation or cool band unless slow allow 0
// - safety timer pauses during fault; resets on stop and restart of charging
// - system floor flag high while system held at minimum voltage
// - input voltage or current limit flags high while limit reduces charge
// - phase code 00 disabled, 01 precharge, 10 fast, 11 done
// - after done, new cycle once battery falls below recharge threshold; code also waits for the top-off timer to end
`ifndef CCS_REGS_VH
`define CCS_REGS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CCS_OFS_CTRL      4'h0
`define CCS_OFS_STAT      4'h4

// ****************************************************************
// control register fields
// ****************************************************************
`define CCS_CTL_CHG_ALLOW 0
`define CCS_CTL_TERM_EN   1
`define CCS_CTL_SAFE_EN   2
`define CCS_CTL_SLOW_EN   3
`define CCS_CTL_WARM_SEL  4
`define CCS_CTL_BOOST_EN  5
`define CCS_CTL_REG_RST   7
`define CCS_CTL_BOOST_HOT_LIMIT_SEL_LO   8
`define CCS_CTL_COOL_LO   10
`define CCS_CTL_FTMR_LO   12
`define CCS_CTL_TOPO_LO   14
`define CCS_CTL_RESET     16'h000F

// ****************************************************************
// status register fields
// ****************************************************************
`define CCS_ST_PHASE_LO   0
`define CCS_ST_TOPO_RUN   2
`define CCS_ST_SRC_LO     3
`define CCS_ST_NTC_FLT    6
`define CCS_ST_FLT_LO     7
`define CCS_ST_SYS_FLOOR  9
`define CCS_ST_VLIM       10
`define CCS_ST_ILIM       11

// ****************************************************************
// codes
// ****************************************************************
`define CCS_PH_OFF        2'h0
`define CCS_PH_PRE        2'h1
`define CCS_PH_FAST       2'h2
`define CCS_PH_DONE       2'h3
`define CCS_FLT_NONE      2'h0
`define CCS_FLT_SAFETY    2'h3
`define CCS_SRC_BOOST     3'h7
`define CCS_SRC_NONE      3'h0
`define CCS_BOOST_HOT_LIMIT_SEL_NOSUSP   2'h3

// ****************************************************************
// timing
// ****************************************************************
`define CCS_CLK_NS        32'h0000000A
`define CCS_TICK_NS       32'h3B9ACA00
`define CCS_LOWV_SEC      17'h01C20
`define CCS_FAST0_SEC     17'h04650
`define CCS_FAST1_SEC     17'h08CA0
`define CCS_FAST2_SEC     17'h0D2F0
`define CCS_FAST3_SEC     17'h11940
`define CCS_TOPO1_SEC     16'h0384
`define CCS_TOPO2_SEC     16'h0708
`define CCS_TOPO3_SEC     16'h0A8C

`endif

// ---- ccs_charge_supervisor.v ----
// charge cycle supervisor: termination, top-off, thermistor bands, safety timer, status
`timescale 1ns/1ns
`include "ccs_regs.vh"

module ccs_charge_supervisor #(
   parameter TICK_CYCLES = `CCS_TICK_NS / `CCS_CLK_NS
) (
   input  wire        clock,
   input  wire        rst_n,
   // avalon-mm slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // charge enable pin, active low, asynchronous
   input  wire        chg_enable_n,
   // comparator flags, synchronous to clock
   input  wire        vbat_above_rechg,
   input  wire        ichg_below_term,
   input  wire        in_icl_reg,
   input  wire        in_vcl_reg,
   input  wire        in_thermal_reg,
   input  wire        ts_in_range,
   input  wire        ts_cool,
   input  wire        ts_warm,
   input  wire        ts_boost_ok,
   input  wire        vbat_below_lowv,
   input  wire        vbat_below_fast,
   input  wire        sys_at_floor,
   input  wire        fault_present,
   input  wire [2:0]  input_source_in,
   // outputs
   output reg  [1:0]  charge_phase_code,
   output reg         batfet_on,
   output reg         boost_run,
   output reg  [2:0]  input_source_code,
   output reg         thermistor_fault,
   output reg         vreg_use_4v1,
   output reg         cool_reduce,
   output reg  [1:0]  cool_current_select,
   output reg         host_alert
);

   // ****************
   // state and registers
   // ****************
   reg  [15:0] ctrl_ff;
   reg  [1:0]  phase_ff;
   reg  [1:0]  nxt_phase;
   reg         topo_run_ff;
   reg  [15:0] topo_len_ff;
   reg  [15:0] topo_cnt_ff;
   reg  [16:0] safe_cnt_ff;
   reg  [1:0]  fault_code_ff;
   reg  [26:0] pre_ff;
   reg         half_ff;
   reg         en_s1_ff;
   reg         en_s2_ff;
   reg         en_s3_ff;
   reg         pin_n_ff;
   reg         user_en_d_ff;
   reg         term_d_ff;
   reg         ack_ff;
   reg         rst_pulse_ff;
   reg  [16:0] safe_lim;
   reg  [15:0] topo_sel_len;

   wire        charge_allow = ctrl_ff[`CCS_CTL_CHG_ALLOW];
   wire        term_allow   = ctrl_ff[`CCS_CTL_TERM_EN];
   wire        safe_allow   = ctrl_ff[`CCS_CTL_SAFE_EN];
   wire        slow_allow   = ctrl_ff[`CCS_CTL_SLOW_EN];
   wire        warm_sel     = ctrl_ff[`CCS_CTL_WARM_SEL];
   wire        boost_en     = ctrl_ff[`CCS_CTL_BOOST_EN];
   wire [1:0]  boost_hot_limit_sel_sel     = ctrl_ff[`CCS_CTL_BOOST_HOT_LIMIT_SEL_LO+1:`CCS_CTL_BOOST_HOT_LIMIT_SEL_LO];
   wire [1:0]  cool_sel     = ctrl_ff[`CCS_CTL_COOL_LO+1:`CCS_CTL_COOL_LO];
   wire [1:0]  ftmr_sel     = ctrl_ff[`CCS_CTL_FTMR_LO+1:`CCS_CTL_FTMR_LO];
   wire [1:0]  topo_sel     = ctrl_ff[`CCS_CTL_TOPO_LO+1:`CCS_CTL_TOPO_LO];

   // ****************
   // bus slave
   // ****************
   wire        req       = avs_read | avs_write;
   wire        wr_ctrl   = avs_write & ack_ff & (avs_address == `CCS_OFS_CTRL);
   wire        reg_reset = wr_ctrl & avs_writedata[`CCS_CTL_REG_RST];
   wire [31:0] stat_word = {20'h00000,
                            in_icl_reg, in_vcl_reg, sys_at_floor,
                            fault_code_ff, thermistor_fault, input_source_code,
                            topo_run_ff, phase_ff};

   // ****************
   // enable pin synchroniser
   // ****************
   // three stages; the held level changes only once stages two and three agree
   always @(posedge clock) begin
      if (!rst_n) begin
         en_s1_ff <= 1'b1;
         en_s2_ff <= 1'b1;
         en_s3_ff <= 1'b1;
         pin_n_ff <= 1'b1;
      end else begin
         en_s1_ff <= chg_enable_n;
         en_s2_ff <= en_s1_ff;
         en_s3_ff <= en_s2_ff;
         if (en_s2_ff == en_s3_ff) begin
            pin_n_ff <= en_s3_ff;
         end
      end
   end

   // ****************
   // derived conditions
   // ****************
   wire user_en     = charge_allow & ~pin_n_ff;
   wire user_en_up  = user_en & ~user_en_d_ff;
   wire safe_fault  = (fault_code_ff == `CCS_FLT_SAFETY);
   wire chg_run     = user_en & ts_in_range & ~safe_fault;
   wire any_reg     = in_icl_reg | in_vcl_reg | in_thermal_reg;
   wire slow_mode   = slow_allow & (any_reg | ts_cool);
   wire paused      = fault_present | ~ts_in_range;
   wire in_fast     = (phase_ff == `CCS_PH_FAST);
   // hold off during regulation or when termination not allowed
   wire term_det    = chg_run & in_fast & vbat_above_rechg & ichg_below_term
                      & ~any_reg & term_allow;
   wire term_rise   = term_det & ~term_d_ff;
   wire recharge    = chg_run & (phase_ff == `CCS_PH_DONE) & ~vbat_above_rechg
                      & ~topo_run_ff;
   wire topo_rst    = user_en_up | term_rise | rst_pulse_ff;

   // one prescaled second tick; in slow mode only every second tick counts
   wire base_tick   = (pre_ff == TICK_CYCLES - 1);
   wire count_tick  = base_tick & ~paused & (~slow_mode | half_ff);
   wire topo_exp    = topo_run_ff & count_tick & (topo_cnt_ff + 16'h0001 >= topo_len_ff);
   wire safe_active = safe_allow & chg_run & (phase_ff != `CCS_PH_DONE);
   wire safe_exp    = safe_active & count_tick & (safe_cnt_ff + 17'h00001 >= safe_lim);

   // ****************
   // limit selection
   // ****************
   // safety limit in seconds and selected top-off length
   always @* begin
      if (vbat_below_lowv) begin
         safe_lim = `CCS_LOWV_SEC;
      end else if (ftmr_sel == 2'h0) begin
         safe_lim = `CCS_FAST0_SEC;
      end else if (ftmr_sel == 2'h1) begin
         safe_lim = `CCS_FAST1_SEC;
      end else if (ftmr_sel == 2'h2) begin
         safe_lim = `CCS_FAST2_SEC;
      end else begin
         safe_lim = `CCS_FAST3_SEC;
      end
      if (topo_sel == 2'h1) begin
         topo_sel_len = `CCS_TOPO1_SEC;
      end else if (topo_sel == 2'h2) begin
         topo_sel_len = `CCS_TOPO2_SEC;
      end else if (topo_sel == 2'h3) begin
         topo_sel_len = `CCS_TOPO3_SEC;
      end else begin
         topo_sel_len = 16'h0000;
      end
   end

   // ****************
   // charge phase machine
   // ****************
   // next phase from enable, battery level and termination
   always @* begin
      nxt_phase = phase_ff;
      case (phase_ff)
         `CCS_PH_OFF: begin
            if (chg_run) begin
               nxt_phase = vbat_below_fast ? `CCS_PH_PRE : `CCS_PH_FAST;
            end
         end
         `CCS_PH_PRE: begin
            if (!chg_run) begin
               nxt_phase = `CCS_PH_OFF;
            end else if (!vbat_below_fast) begin
               nxt_phase = `CCS_PH_FAST;
            end
         end
         `CCS_PH_FAST: begin
            if (!chg_run) begin
               nxt_phase = `CCS_PH_OFF;
            end else if (term_det) begin
               nxt_phase = `CCS_PH_DONE;
            end
         end
         default: begin
            if (!chg_run) begin
               nxt_phase = `CCS_PH_OFF;
            end else if (recharge) begin
               nxt_phase = vbat_below_fast ? `CCS_PH_PRE : `CCS_PH_FAST;
            end
         end
      endcase
   end

   // ****************
   // sequential core
   // ****************
   // control register, timers, phase and fault
   always @(posedge clock) begin
      if (!rst_n) begin
         ctrl_ff       <= `CCS_CTL_RESET;
         phase_ff      <= `CCS_PH_OFF;
         topo_run_ff   <= 1'b0;
         topo_len_ff   <= 16'h0000;
         topo_cnt_ff   <= 16'h0000;
         safe_cnt_ff   <= 17'h00000;
         fault_code_ff <= `CCS_FLT_NONE;
         pre_ff        <= 27'h0000000;
         half_ff       <= 1'b0;
         user_en_d_ff  <= 1'b0;
         term_d_ff     <= 1'b0;
         rst_pulse_ff  <= 1'b0;
      end else begin
         user_en_d_ff <= user_en;
         term_d_ff    <= term_det;
         rst_pulse_ff <= reg_reset;
         phase_ff     <= nxt_phase;
         // control register, register reset returns defaults
         if (reg_reset) begin
            ctrl_ff <= `CCS_CTL_RESET;
         end else if (wr_ctrl) begin
            ctrl_ff <= avs_writedata[15:0] & 16'hFF7F;
         end
         // prescaler and half-rate toggle
         if (base_tick) begin
            pre_ff <= 27'h0000000;
            if (!paused) begin
               half_ff <= ~half_ff;
            end
         end else begin
            pre_ff <= pre_ff + 27'h0000001;
         end
         // top-off: length captured at termination only
         if (topo_rst && !term_rise) begin
            topo_run_ff <= 1'b0;
            topo_cnt_ff <= 16'h0000;
         end else if (term_rise && nxt_phase == `CCS_PH_DONE) begin
            topo_len_ff <= topo_sel_len;
            topo_cnt_ff <= 16'h0000;
            topo_run_ff <= (topo_sel_len != 16'h0000);
         end else if (topo_exp || !chg_run) begin
            topo_run_ff <= 1'b0;
         end else if (topo_run_ff && count_tick) begin
            topo_cnt_ff <= topo_cnt_ff + 16'h0001;
         end
         // safety timer
         if (user_en_up || !safe_allow || reg_reset) begin
            safe_cnt_ff <= 17'h00000;
         end else if (recharge) begin
            safe_cnt_ff <= 17'h00000;
         end else if (safe_active && count_tick) begin
            safe_cnt_ff <= safe_cnt_ff + 17'h00001;
         end
         // fault code: set wins, cleared on restart or reset
         if (safe_exp) begin
            fault_code_ff <= `CCS_FLT_SAFETY;
         end else if (user_en_up || !safe_allow || reg_reset) begin
            fault_code_ff <= `CCS_FLT_NONE;
         end
      end
   end

   // ****************
   // registered outputs
   // ****************
   // phase, switch, band limits, boost supervision and alert
   always @(posedge clock) begin
      if (!rst_n) begin
         charge_phase_code   <= `CCS_PH_OFF;
         batfet_on           <= 1'b0;
         boost_run           <= 1'b0;
         input_source_code   <= `CCS_SRC_NONE;
         thermistor_fault    <= 1'b0;
         vreg_use_4v1        <= 1'b0;
         cool_reduce         <= 1'b0;
         cool_current_select <= 2'h0;
         host_alert          <= 1'b0;
      end else begin
         charge_phase_code   <= nxt_phase;
         // switch off once done and top-off finished
         batfet_on           <= chg_run & (nxt_phase != `CCS_PH_DONE | topo_run_ff
                                & ~topo_exp);
         vreg_use_4v1        <= ts_warm & warm_sel;
         cool_reduce         <= ts_cool & chg_run;
         cool_current_select <= cool_sel;
         thermistor_fault    <= boost_en & ~ts_boost_ok;
         boost_run           <= boost_en & (ts_boost_ok
                                | (boost_hot_limit_sel_sel == `CCS_BOOST_HOT_LIMIT_SEL_NOSUSP));
         if (boost_en && (ts_boost_ok || boost_hot_limit_sel_sel == `CCS_BOOST_HOT_LIMIT_SEL_NOSUSP)) begin
            input_source_code <= `CCS_SRC_BOOST;
         end else if (boost_en) begin
            input_source_code <= `CCS_SRC_NONE;
         end else begin
            input_source_code <= input_source_in;
         end
         // one pulse for termination/top-off start, expiry, safety fault
         host_alert <= (term_det & in_fast) | topo_exp | safe_exp;
      end
   end

   // ****************
   // bus answer
   // ****************
   // waitrequest drops one cycle after a request is seen
   always @(posedge clock) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         ack_ff          <= 1'b0;
         avs_readdata    <= 32'h00000000;
      end else begin
         if (req && !ack_ff && avs_waitrequest) begin
            ack_ff          <= 1'b1;
            avs_waitrequest <= 1'b0;
            if (avs_address == `CCS_OFS_CTRL) begin
               avs_readdata <= {16'h0000, ctrl_ff};
            end else if (avs_address == `CCS_OFS_STAT) begin
               avs_readdata <= stat_word;
            end else begin
               avs_readdata <= 32'h00000000;
            end
         end else begin
            ack_ff          <= 1'b0;
            avs_waitrequest <= 1'b1;
         end
      end
   end

endmodule // ccs_charge_supervisor

// ---- ccs_sup_properties.sv ----
// concurrent checks on the ports of the charge supervisor
`timescale 1ns/1ns
module ccs_sup_checker (
   input logic       clock,
   input logic       rst_n,
   input logic       avs_waitrequest,
   input logic       vbat_above_rechg,
   input logic       ichg_below_term,
   input logic       in_icl_reg,
   input logic       in_vcl_reg,
   input logic       in_thermal_reg,
   input logic       ts_cool,
   input logic       ts_warm,
   input logic       ts_boost_ok,
   input logic       vbat_below_fast,
   input logic [1:0] charge_phase_code,
   input logic       boost_run,
   input logic [2:0] input_source_code,
   input logic       thermistor_fault,
   input logic       vreg_use_4v1,
   input logic       cool_reduce,
   input logic       host_alert
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // fast to done step seen on the phase code
   sequence term_step;
      charge_phase_code == 2'h3 && $past(charge_phase_code) == 2'h2;
   endsequence

   bus_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   reg_hold_term_a: assert property ((charge_phase_code == 2'h2 &&
      (in_icl_reg || in_vcl_reg || in_thermal_reg)) |=> charge_phase_code != 2'h3)
      else $error("termination during regulation");
   term_cause_a: assert property (term_step |-> $past(vbat_above_rechg && ichg_below_term))
      else $error("termination without its cause");
   term_alert_a: assert property (term_step |-> host_alert)
      else $error("termination without alert pulse");
   alert_pulse_a: assert property (host_alert |=> !host_alert)
      else $error("alert longer than one cycle");
   boost_fault_a: assert property ((boost_run && !ts_boost_ok)
      |=> (thermistor_fault || !boost_run))
      else $error("thermistor fault missing in boost");
   boost_src_a: assert property ((!boost_run && thermistor_fault) |-> input_source_code == 3'h0)
      else $error("source code not cleared on boost suspend");
   warm_volt_a: assert property (!ts_warm |=> !vreg_use_4v1)
      else $error("reduced voltage outside warm band");
   cool_curr_a: assert property (!ts_cool |=> !cool_reduce)
      else $error("reduced current outside cool band");
   pre_phase_a: assert property (charge_phase_code == 2'h1 |-> $past(vbat_below_fast))
      else $error("precharge code above precharge level");

   // main scenarios reached
   cover property (term_step);
   cover property (thermistor_fault && boost_run);
   cover property (cool_reduce);
endmodule // ccs_sup_checker

bind ccs_charge_supervisor ccs_sup_checker u_chk (.clock(clock), .rst_n(rst_n),
   .avs_waitrequest(avs_waitrequest), .vbat_above_rechg(vbat_above_rechg),
   .ichg_below_term(ichg_below_term), .in_icl_reg(in_icl_reg), .in_vcl_reg(in_vcl_reg),
   .in_thermal_reg(in_thermal_reg), .ts_cool(ts_cool), .ts_warm(ts_warm),
   .ts_boost_ok(ts_boost_ok), .vbat_below_fast(vbat_below_fast),
   .charge_phase_code(charge_phase_code), .boost_run(boost_run),
   .input_source_code(input_source_code), .thermistor_fault(thermistor_fault),
   .vreg_use_4v1(vreg_use_4v1), .cool_reduce(cool_reduce), .host_alert(host_alert));

// ---- ccs_host_model.sv ----
// host model: avalon-mm master that writes settings and reads status
`timescale 1ns/1ns
module ccs_host_model (
   input  logic        clock,
   input  logic [31:0] avs_readdata,
   input  logic        avs_waitrequest,
   output logic [3:0]  avs_address,
   output logic        avs_read,
   output logic        avs_write,
   output logic [31:0] avs_writedata
);
   // bus idle at time zero
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end

   // one access, held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                         output logic [31:0] rdat);
      @(posedge clock);
      avs_address <= adr;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule // ccs_host_model

// ---- tb_top.sv ----
// self-checking testbench of the charge supervisor
`timescale 1ns/1ns
`include "ccs_regs.vh"
module tb_top;
   logic        clock, rst_n, chg_enable_n, vbat_above_rechg, ichg_below_term;
   logic        in_icl_reg, in_vcl_reg, in_thermal_reg, ts_in_range, ts_cool, ts_warm;
   logic        ts_boost_ok, vbat_below_lowv, vbat_below_fast, sys_at_floor, fault_present;
   logic [2:0]  input_source_in, input_source_code;
   logic [3:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest, batfet_on, boost_run;
   logic        thermistor_fault, vreg_use_4v1, cool_reduce, host_alert;
   logic [31:0] avs_writedata, avs_readdata, v;
   logic [1:0]  charge_phase_code, cool_current_select;
   int          bad_count, comparisons, alerts, a0, cycles;

   ccs_charge_supervisor #(.TICK_CYCLES(4)) DUT (.clock(clock), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .chg_enable_n(chg_enable_n),
      .vbat_above_rechg(vbat_above_rechg), .ichg_below_term(ichg_below_term),
      .in_icl_reg(in_icl_reg), .in_vcl_reg(in_vcl_reg), .in_thermal_reg(in_thermal_reg),
      .ts_in_range(ts_in_range), .ts_cool(ts_cool), .ts_warm(ts_warm),
      .ts_boost_ok(ts_boost_ok), .vbat_below_lowv(vbat_below_lowv),
      .vbat_below_fast(vbat_below_fast), .sys_at_floor(sys_at_floor),
      .fault_present(fault_present), .input_source_in(input_source_in),
      .charge_phase_code(charge_phase_code), .batfet_on(batfet_on), .boost_run(boost_run),
      .input_source_code(input_source_code), .thermistor_fault(thermistor_fault),
      .vreg_use_4v1(vreg_use_4v1), .cool_reduce(cool_reduce),
      .cool_current_select(cool_current_select), .host_alert(host_alert));

   ccs_host_model host (.clock(clock), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata));

   // ****************
   // clock, cycle ceiling and alert counter
   // ****************
   initial clock = 1'b0;
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (host_alert === 1'b1) alerts <= alerts + 1;
      if (cycles == 60000) begin
         bad_count++;
         complete_run();
      end
   end

   // ****************
   // helpers
   // ****************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [3:0] adr);
      host.access(1'b0, adr, 32'h0, v);
   endtask
   task automatic wr(input logic [15:0] d);
      host.access(1'b1, `CCS_OFS_CTRL, {16'h0, d}, v);
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic complete_run;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      rd(`CCS_OFS_CTRL);
      check("ctrl reset", v, 32'h0000000F);
      rd(4'h8);
      check("unmapped read", v, 32'h0);
      check("phase after reset", 32'(charge_phase_code), 32'h0);
   endtask
   task automatic t_charge;
      ts_in_range <= 1'b1;
      vbat_below_fast <= 1'b1;
      chg_enable_n <= 1'b0;
      w(8);
      check("precharge", 32'(charge_phase_code), 32'h1);
      vbat_below_fast <= 1'b0;
      w(2);
      check("fast", 32'(charge_phase_code), 32'h2);
      ts_in_range <= 1'b0;
      w(2);
      check("suspended", 32'(charge_phase_code), 32'h0);
      ts_in_range <= 1'b1;
      w(2);
      check("resumed", 32'(charge_phase_code), 32'h2);
   endtask
   task automatic t_term;
      vbat_above_rechg <= 1'b1;
      ichg_below_term <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         {in_icl_reg, in_vcl_reg, in_thermal_reg} <= 3'h1 << k;
         w(4);
         check("held in regulation", 32'(charge_phase_code), 32'h2);
      end
      wr(16'h000D); // host clears terminate allow first
      {in_icl_reg, in_vcl_reg, in_thermal_reg} <= 3'h0;
      w(4);
      check("terminate blocked", 32'(charge_phase_code), 32'h2);
      a0 = alerts;
      wr(16'h400F);
      w(3);
      check("done code", 32'(charge_phase_code), 32'h3);
      check("one alert", 32'(alerts - a0), 32'h1);
      wr(16'h000F);
      rd(`CCS_OFS_STAT);
      check("top-off running", 32'(v[2]), 32'h1);
      w(3500);
      rd(`CCS_OFS_STAT);
      check("top-off still running", 32'(v[2]), 32'h1);
      w(200);
      rd(`CCS_OFS_STAT);
      check("top-off ended", 32'(v[2]), 32'h0);
      check("expiry alert", 32'(alerts - a0), 32'h2);
      check("battery switch off", 32'(batfet_on), 32'h0);
      vbat_above_rechg <= 1'b0;
      ichg_below_term <= 1'b0;
      w(3);
      check("recharge", 32'(charge_phase_code), 32'h2);
   endtask
   task automatic t_safety;
      chg_enable_n <= 1'b1;
      w(10);
      check("pin disable", 32'(charge_phase_code), 32'h0);
      vbat_below_lowv <= 1'b1;
      chg_enable_n <= 1'b0;
      w(27900);
      rd(`CCS_OFS_STAT);
      check("no early expiry", 32'(v[8:7]), 32'h0);
      a0 = alerts;
      while (host_alert !== 1'b1) @(posedge clock);
      w(2);
      check("safety alert", 32'(alerts - a0), 32'h1);
      rd(`CCS_OFS_STAT);
      check("safety fault", 32'(v[8:7]), 32'h3);
      vbat_below_lowv <= 1'b0;
      wr(16'h0080);
      rd(`CCS_OFS_CTRL);
      check("ctrl reloaded", v, 32'h0000000F);
      rd(`CCS_OFS_STAT);
      check("fault cleared", 32'(v[8:7]), 32'h0);
   endtask
   task automatic t_temp;
      ts_warm <= 1'b1;
      wr(16'h001F);
      w(2);
      check("warm 4v1", 32'(vreg_use_4v1), 32'h1);
      wr(16'h000F);
      w(2);
      check("warm target", 32'(vreg_use_4v1), 32'h0);
      ts_warm <= 1'b0;
      ts_cool <= 1'b1;
      wr(16'h080F);
      w(2);
      check("cool reduce", 32'(cool_reduce), 32'h1);
      check("cool select", 32'(cool_current_select), 32'h2);
      ts_cool <= 1'b0;
      w(2);
      check("cool off", 32'(cool_reduce), 32'h0);
   endtask
   task automatic t_boost;
      ts_boost_ok <= 1'b1;
      input_source_in <= 3'h2;
      wr(16'h002F);
      w(2);
      check("boost on", 32'(input_source_code), 32'h7);
      ts_boost_ok <= 1'b0;
      w(2);
      check("boost held", 32'(boost_run), 32'h0);
      check("source cleared", 32'(input_source_code), 32'h0);
      check("thermistor_fault", 32'(thermistor_fault), 32'h1);
      wr(16'h032F);
      w(2);
      check("hot limit keeps boost", 32'(boost_run), 32'h1);
      check("hot limit fault", 32'(thermistor_fault), 32'h1);
      ts_boost_ok <= 1'b1;
      w(2);
      check("thermistor_fault cleared", 32'(thermistor_fault), 32'h0);
      wr(16'h000F);
   endtask
   task automatic t_flags;
      for (int k = 0; k < 2; k++) begin
         {in_icl_reg, in_vcl_reg, sys_at_floor} <= k ? 3'h2 : 3'h5;
         w(1);
         rd(`CCS_OFS_STAT);
         check("status flags", 32'(v[11:9]), k ? 32'h2 : 32'h5);
      end
      {in_icl_reg, in_vcl_reg, sys_at_floor} <= 3'h0;
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      rst_n = 1'b0;
      chg_enable_n = 1'b1;
      input_source_in = 3'h0;
      {vbat_above_rechg, ichg_below_term, in_icl_reg, in_vcl_reg, in_thermal_reg, ts_in_range,
       ts_cool, ts_warm, ts_boost_ok, vbat_below_lowv, vbat_below_fast, sys_at_floor,
       fault_present} = 13'h0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_charge();
      t_term();
      t_safety();
      t_temp();
      t_boost();
      t_flags();
      complete_run();
   end
endmodule // tb_top
